// ### hdl/seg_bus_cfg.svh
// Constants of the segmented packet bus and its four-lane coding logic.
// Assumes inclusion by bare name from the package and the design file.
`ifndef SEG_BUS_CFG_SVH
`define SEG_BUS_CFG_SVH

`define SEG_COUNT 4
`define SEG_WIDTH 128
`define EMPTY_WIDTH 4
`define LANE_COUNT 4
`define LANE_WIDTH 80
`define BLOCK_WIDTH 64
`define CTRL_WIDTH 16
`define WIDE_CTRL_LSB 64
`define NARROW_CTRL_LSB 16
`define CHUNK_WIDTH 16
`define FIFO_DEPTH 16
`define TX_READY_SLACK 4
`define DESKEW_DEPTH 4
`define SYNC_DATA 2'h1
`define SYNC_IDLE 2'h2
`define SCRAMBLE_TAP_A 38
`define SCRAMBLE_TAP_B 57
`define SCRAMBLE_STATE_WIDTH 58

`endif

// ### hdl/seg_bus_pkg.sv
// Types shared by the segmented packet bus logic.
// Assumes the constants header is on the include path.
`include "seg_bus_cfg.svh"
`default_nettype none

package seg_bus_pkg;

    // One 128-bit segment with its qualifiers; byte 0 of a segment sits in payload[127:120].
    typedef struct packed {
        logic [`SEG_WIDTH-1:0] payload;
        logic valid;
        logic first;
        logic last;
        logic bad;
        logic [`EMPTY_WIDTH-1:0] empty_count;
    } segment_t;

    typedef segment_t [`SEG_COUNT-1:0] bus_t;

    // The 16-bit group that travels beside each lane's payload bits.
    typedef struct packed {
        logic [1:0] sync;
        logic [1:0] lane_id;
        logic pair;
        logic [1:0] chunk;
        logic marker;
        logic valid;
        logic first;
        logic last;
        logic bad;
        logic [`EMPTY_WIDTH-1:0] empty_count;
    } lane_ctrl_t;

    typedef logic [`LANE_COUNT-1:0][`LANE_WIDTH-1:0] lanes_t;

endpackage

`default_nettype wire

// ### hdl/segmented_packet_bus_100g.sv
// Segmented packet bus of a 100 Gb/s port with its transmit word buffer and lane coding.
// Assumes one core clock shared by transmit, receive and transceiver lanes.
`include "seg_bus_cfg.svh"
`default_nettype none

// ****************************************************************
// Word buffer
// ****************************************************************
// DEPTH must be a power of two so that the pointers wrap on their own.
module packet_word_fifo #(
    parameter int WIDTH = 544,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] level;
    wire push = i_in_valid && o_in_ready;
    wire pop = o_out_valid && i_out_ready;

    assign o_in_ready = level != (AW+1)'(DEPTH);
    assign o_out_valid = level != '0;
    assign o_out_data = mem[rd_ptr];
    assign o_level = level;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= '0;
        end
        else
        begin
            wr_ptr <= wr_ptr + AW'(push);
            rd_ptr <= rd_ptr + AW'(pop);
            level <= level + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr] <= i_in_data;
    end
endmodule // packet_word_fifo

// ****************************************************************
// Packet bus and lane logic
// ****************************************************************
module segmented_packet_bus_100g #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH,
    parameter int READY_SLACK = `TX_READY_SLACK
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ten_lane_mode,
    input wire seg_bus_pkg::bus_t i_tx_bus,
    output logic o_tx_ready,
    output logic o_tx_overflow,
    output seg_bus_pkg::lanes_t o_serdes_tx,
    input wire seg_bus_pkg::lanes_t i_serdes_rx,
    output seg_bus_pkg::bus_t o_rx_bus,
    output logic o_rx_locked
);
    localparam int WORD_W = $bits(seg_bus_pkg::bus_t);
    localparam int NL = `LANE_COUNT;
    localparam int SW = `SCRAMBLE_STATE_WIDTH;

    // Serial self-synchronising scrambler, LSB first; desc selects the receive form.
    function automatic logic [SW+`BLOCK_WIDTH-1:0] scramble(input logic [`BLOCK_WIDTH-1:0] d,
                                                            input logic [SW-1:0] s, input logic desc);
        logic [SW-1:0] st;
        logic [`BLOCK_WIDTH-1:0] q;
        st = s;
        q = '0;
        for (int i = 0; i < `BLOCK_WIDTH; i++)
        begin
            q[i] = d[i] ^ st[`SCRAMBLE_TAP_A] ^ st[`SCRAMBLE_TAP_B];
            st = {st[SW-2:0], desc ? d[i] : q[i]};
        end
        return {st, q};
    endfunction

    // ****************************************************************
    // Mode strap
    // ****************************************************************
    logic mode_meta;
    logic narrow;
    always_ff @(posedge i_clk)
    begin
        mode_meta <= i_ten_lane_mode;
        narrow <= mode_meta;
    end
    // Four beats of 16 bits carry one block in narrow mode, one beat in wide mode.
    wire [2:0] last_beat = narrow ? 3'h7 : 3'h1;
    wire [1:0] last_chunk = narrow ? 2'h3 : 2'h0;

    // ****************************************************************
    // Transmit capture
    // ****************************************************************
    seg_bus_pkg::bus_t tx_clean;
    logic [`SEG_COUNT-1:0] tx_valids;
    genvar g;
    generate
        for (g = 0; g < `SEG_COUNT; g++)
        begin : g_tx_seg
            wire v = i_tx_bus[g].valid;
            wire vl = v && i_tx_bus[g].last;
            wire [`EMPTY_WIDTH-1:0] e = i_tx_bus[g].empty_count;
            assign tx_valids[g] = v;
            assign tx_clean[g].payload = v ? i_tx_bus[g].payload : '0;
            assign tx_clean[g].valid = v;
            assign tx_clean[g].first = v && i_tx_bus[g].first;
            assign tx_clean[g].last = vl;
            assign tx_clean[g].bad = vl && i_tx_bus[g].bad;
            assign tx_clean[g].empty_count = !vl ? 4'h0 : i_tx_bus[g].bad ? {e[3], 3'h0} : e;
        end
    endgenerate

    wire tx_push = |tx_valids;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [WORD_W-1:0] fifo_out;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;

    packet_word_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_in_valid(tx_push),
        .o_in_ready(fifo_in_ready),
        .i_in_data(tx_clean),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out),
        .o_level(fifo_level)
    );

    // Ready falls early enough that four more words still fit.
    assign o_tx_ready = fifo_level < ($clog2(FIFO_DEPTH)+1)'(FIFO_DEPTH - READY_SLACK);

    // ****************************************************************
    // Transmit lanes
    // ****************************************************************
    logic [2:0] tx_beat;
    logic [2:0] mark_count;
    seg_bus_pkg::bus_t tx_word;
    logic [NL-1:0][SW-1:0] tx_scr;
    wire tx_word_end = tx_beat == last_beat;
    wire tx_pair = narrow ? tx_beat[2] : tx_beat[0];
    wire [1:0] tx_chunk = narrow ? tx_beat[1:0] : 2'h0;
    assign fifo_pop = tx_word_end;

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_beat <= 3'h0;
            mark_count <= 3'h0;
            tx_word <= '0;
            o_tx_overflow <= 1'b0;
        end
        else
        begin
            tx_beat <= tx_word_end ? 3'h0 : tx_beat + 3'h1;
            mark_count <= mark_count + 3'(tx_word_end);
            if (tx_word_end)
                tx_word <= fifo_out_valid ? seg_bus_pkg::bus_t'(fifo_out) : '0;
            o_tx_overflow <= tx_push && !fifo_in_ready;
        end
    end

    generate
        for (g = 0; g < NL; g++)
        begin : g_tx_lane
            seg_bus_pkg::segment_t seg;
            seg_bus_pkg::lane_ctrl_t ctrl;
            logic [SW+`BLOCK_WIDTH-1:0] scr;
            // Lanes 0 and 1 carry one segment of a pair, lanes 2 and 3 the other.
            assign seg = tx_word[2 * tx_pair + g / 2];
            assign scr = scramble((g % 2) == 0 ? seg.payload[127:64] : seg.payload[63:0], tx_scr[g], 1'b0);
            assign ctrl.sync = seg.valid ? `SYNC_DATA : `SYNC_IDLE;
            assign ctrl.lane_id = 2'(g);
            assign ctrl.pair = tx_pair;
            assign ctrl.chunk = tx_chunk;
            assign ctrl.marker = tx_beat == 3'h0 && mark_count == 3'h0;
            assign ctrl.valid = seg.valid;
            assign ctrl.first = seg.first;
            assign ctrl.last = seg.last;
            assign ctrl.bad = seg.bad;
            assign ctrl.empty_count = seg.empty_count;

            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    tx_scr[g] <= '0;
                    o_serdes_tx[g] <= '0;
                end
                else
                begin
                    if (tx_chunk == last_chunk)
                        tx_scr[g] <= scr[SW+`BLOCK_WIDTH-1:`BLOCK_WIDTH];
                    o_serdes_tx[g] <= narrow ? {48'h0, ctrl, scr[16 * tx_chunk +: 16]} : {ctrl, scr[63:0]};
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Receive deskew and reorder
    // ****************************************************************
    seg_bus_pkg::lanes_t rx_meta;
    seg_bus_pkg::lanes_t rx_in;
    always_ff @(posedge i_clk)
    begin
        rx_meta <= i_serdes_rx;
        rx_in <= rx_meta;
    end

    logic [NL-1:0][`DESKEW_DEPTH-1:0][`LANE_WIDTH-1:0] hist;
    logic [NL-1:0][`DESKEW_DEPTH-1:0] marks;
    logic [NL-1:0][1:0] tap;
    logic [NL-1:0] seen;
    logic [NL-1:0] newest;
    seg_bus_pkg::lanes_t aligned;
    seg_bus_pkg::lane_ctrl_t [NL-1:0] al_ctrl;

    generate
        for (g = 0; g < NL; g++)
        begin : g_deskew
            logic [1:0] first_mark;
            for (genvar k = 0; k < `DESKEW_DEPTH; k++)
            begin : g_tap
                assign marks[g][k] = narrow ? hist[g][k][`NARROW_CTRL_LSB + 8] : hist[g][k][`WIDE_CTRL_LSB + 8];
            end
            assign seen[g] = |marks[g];
            assign newest[g] = marks[g][0];
            always_comb
            begin
                first_mark = 2'h0;
                for (int k = `DESKEW_DEPTH - 1; k >= 0; k--)
                    if (marks[g][k])
                        first_mark = 2'(k);
            end
            assign aligned[g] = hist[g][tap[g]];
            assign al_ctrl[g] = narrow ? aligned[g][31:16] : aligned[g][79:64];
            always_ff @(posedge i_clk)
            begin
                hist[g] <= {hist[g][`DESKEW_DEPTH-2:0], rx_in[g]};
                if (i_reset)
                    tap[g] <= 2'h0;
                else if (&seen && |newest)
                    tap[g] <= first_mark;
            end
        end
    endgenerate

    // Lock once every lane has shown the marker inside the deskew window together.
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
            o_rx_locked <= 1'b0;
        else if (&seen && |newest)
            o_rx_locked <= 1'b1;
    end

    seg_bus_pkg::lanes_t ordered;
    always_comb
    begin
        ordered = aligned;
        for (int j = 0; j < NL; j++)
            for (int p = 0; p < NL; p++)
                if (al_ctrl[p].lane_id == 2'(j))
                    ordered[j] = aligned[p];
    end

    // ****************************************************************
    // Receive decode and rebuild
    // ****************************************************************
    logic [NL-1:0][`BLOCK_WIDTH-1:0] acc;
    logic [NL-1:0][SW-1:0] rx_scr;
    logic [NL-1:0][`BLOCK_WIDTH-1:0] plain;
    seg_bus_pkg::lane_ctrl_t [NL-1:0] rx_ctrl;
    logic [NL-1:0] code_err;
    seg_bus_pkg::segment_t [1:0] pair_seg;
    seg_bus_pkg::segment_t [1:0] held;

    generate
        for (g = 0; g < NL; g++)
        begin : g_rx_lane
            logic [`BLOCK_WIDTH-1:0] block;
            logic [SW+`BLOCK_WIDTH-1:0] dsc;
            assign rx_ctrl[g] = narrow ? ordered[g][31:16] : ordered[g][79:64];
            assign block = narrow ? {ordered[g][15:0], acc[g][47:0]} : ordered[g][63:0];
            assign dsc = scramble(block, rx_scr[g], 1'b1);
            assign plain[g] = dsc[`BLOCK_WIDTH-1:0];
            assign code_err[g] = rx_ctrl[g].sync != `SYNC_DATA && rx_ctrl[g].sync != `SYNC_IDLE;
            always_ff @(posedge i_clk)
            begin
                if (i_reset)
                begin
                    acc[g] <= '0;
                    rx_scr[g] <= '0;
                end
                else
                begin
                    acc[g][16 * rx_ctrl[g].chunk +: 16] <= ordered[g][15:0];
                    if (rx_ctrl[g].chunk == last_chunk)
                        rx_scr[g] <= dsc[SW+`BLOCK_WIDTH-1:`BLOCK_WIDTH];
                end
            end
        end

        for (g = 0; g < 2; g++)
        begin : g_rx_seg
            seg_bus_pkg::lane_ctrl_t c;
            wire v;
            wire bad;
            assign c = rx_ctrl[2 * g];
            assign v = c.valid && o_rx_locked;
            assign bad = v && c.last && (c.bad || code_err[2 * g] || code_err[2 * g + 1]);
            assign pair_seg[g].payload = v ? {plain[2 * g], plain[2 * g + 1]} : '0;
            assign pair_seg[g].valid = v;
            assign pair_seg[g].first = v && c.first;
            assign pair_seg[g].last = v && c.last;
            assign pair_seg[g].bad = bad;
            assign pair_seg[g].empty_count = !(v && c.last) ? 4'h0 : bad ? {c.empty_count[3], 3'h0} : c.empty_count;
        end
    endgenerate

    wire block_done = rx_ctrl[0].chunk == last_chunk;
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            held <= '0;
            o_rx_bus <= '0;
        end
        else
        begin
            if (block_done && !rx_ctrl[0].pair)
                held <= pair_seg;
            // The bus has no back-pressure, so a finished word leaves at once and empty cycles show no valid.
            if (block_done && rx_ctrl[0].pair)
                o_rx_bus <= {pair_seg, held};
            else
                o_rx_bus <= '0;
        end
    end
endmodule // segmented_packet_bus_100g

`default_nettype wire

// ### test/segmented_packet_bus_100g_sva.sv
// Port checker for the segmented packet bus block, attached by bind.
// Assumes one core clock and a synchronous active-high reset.
`default_nettype none

module segmented_packet_bus_100g_sva #(
    parameter int FIFO_DEPTH = 16,
    parameter int READY_SLACK = 4
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ten_lane_mode,
    input wire seg_bus_pkg::bus_t i_tx_bus,
    input wire logic o_tx_ready,
    input wire logic o_tx_overflow,
    input wire seg_bus_pkg::lanes_t o_serdes_tx,
    input wire seg_bus_pkg::lanes_t i_serdes_rx,
    input wire seg_bus_pkg::bus_t o_rx_bus,
    input wire logic o_rx_locked
);
    logic tx_any;
    logic rx_any;
    logic rx_empty_ok;
    logic narrow_clean;
    logic sync_legal;
    logic push_blocked;

    always_comb
    begin
        tx_any = 1'b0;
        rx_any = 1'b0;
        rx_empty_ok = 1'b1;
        narrow_clean = 1'b1;
        sync_legal = 1'b1;
        for (int s = 0; s < 4; s++)
        begin
            tx_any = tx_any | i_tx_bus[s].valid;
            rx_any = rx_any | o_rx_bus[s].valid;
            rx_empty_ok = rx_empty_ok & !(o_rx_bus[s].valid && o_rx_bus[s].bad && o_rx_bus[s].empty_count[2:0] != 3'h0);
            narrow_clean = narrow_clean & (o_serdes_tx[s][79:32] == 48'h0);
            sync_legal = sync_legal & (o_serdes_tx[s][79:78] == 2'h1 || o_serdes_tx[s][79:78] == 2'h2);
        end
    end
    assign push_blocked = !o_tx_ready && tx_any;

    // Counts writes offered while ready is low; the buffer must absorb the slack's worth before any overflow.
    logic [7:0] late_writes;
    always_ff @(posedge i_clk)
    begin
        if (i_reset || o_tx_ready)
            late_writes <= 8'h00;
        else if (tx_any && late_writes != 8'hFF)
            late_writes <= late_writes + 8'h01;
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);

    sequence s_word;
        rx_any;
    endsequence
    sequence s_quiet;
        o_tx_ready && !o_tx_overflow && !o_rx_locked && o_rx_bus == '0 && o_serdes_tx == '0;
    endsequence

    property p_reset_quiet;
        disable iff (1'b0) i_reset |=> s_quiet;
    endproperty
    property p_rx_one_cycle;
        s_word |=> !rx_any;
    endproperty
    property p_rx_idle_zero;
        !rx_any |-> o_rx_bus == '0;
    endproperty
    property p_rx_empty;
        rx_empty_ok;
    endproperty
    property p_lock_holds;
        o_rx_locked |=> o_rx_locked;
    endproperty
    property p_word_needs_lock;
        s_word |-> o_rx_locked;
    endproperty
    property p_ready_falls;
        $fell(o_tx_ready) |-> $past(tx_any);
    endproperty
    property p_overflow_cause;
        o_tx_overflow |-> $past(push_blocked);
    endproperty
    property p_overflow_late;
        o_tx_overflow |-> late_writes > 8'(READY_SLACK);
    endproperty
    property p_narrow_clean;
        i_ten_lane_mode |-> narrow_clean;
    endproperty
    property p_wide_sync;
        !i_ten_lane_mode && !$past(i_reset) && !$past(i_reset, 2) |-> sync_legal;
    endproperty

    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not quiet after reset");
    a_rx_one_cycle: assert property (p_rx_one_cycle) else $error("receive word held too long");
    a_rx_idle_zero: assert property (p_rx_idle_zero) else $error("receive bus not zero when idle");
    a_rx_empty: assert property (p_rx_empty) else $error("bad word with nonzero low empty bits");
    a_lock_holds: assert property (p_lock_holds) else $error("lock dropped without reset");
    a_word_needs_lock: assert property (p_word_needs_lock) else $error("word before deskew lock");
    a_ready_falls: assert property (p_ready_falls) else $error("ready fell without a push");
    a_overflow_cause: assert property (p_overflow_cause) else $error("overflow without blocked push");
    a_overflow_late: assert property (p_overflow_late) else $error("overflow before slack writes used");
    a_narrow_clean: assert property (p_narrow_clean) else $error("narrow lane upper bits not zero");
    a_wide_sync: assert property (p_wide_sync) else $error("illegal lane sync header");
endmodule // segmented_packet_bus_100g_sva

bind segmented_packet_bus_100g segmented_packet_bus_100g_sva #(
    .FIFO_DEPTH(FIFO_DEPTH),
    .READY_SLACK(READY_SLACK)
) sva_u (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_ten_lane_mode(i_ten_lane_mode),
    .i_tx_bus(i_tx_bus),
    .o_tx_ready(o_tx_ready),
    .o_tx_overflow(o_tx_overflow),
    .o_serdes_tx(o_serdes_tx),
    .i_serdes_rx(i_serdes_rx),
    .o_rx_bus(o_rx_bus),
    .o_rx_locked(o_rx_locked)
);

`default_nettype wire

// ### test/user_packet_agent.sv
// Model of the user logic that writes packet words into the transmit side.
// Assumes the core clock and the block's transmit ready level.
`default_nettype none

module user_packet_agent (
    input wire logic i_clk,
    input wire logic i_ready,
    output var seg_bus_pkg::bus_t o_tx_bus
);
    initial
    begin
        o_tx_bus = '0;
    end

    // Released lines show the inverse of the last word, so sampling them without valid is caught.
    function automatic seg_bus_pkg::bus_t idle_of(input seg_bus_pkg::bus_t w);
        seg_bus_pkg::bus_t v;
        v = ~w;
        for (int s = 0; s < 4; s++)
        begin
            v[s].valid = 1'b0;
        end
        return v;
    endfunction

    task automatic send(input seg_bus_pkg::bus_t w, output bit ok);
        int n;
        n = 0;
        @(negedge i_clk);
        while (!i_ready && n < 400)
        begin
            @(negedge i_clk);
            n++;
        end
        ok = (i_ready === 1'b1);
        if (ok)
        begin
            @(posedge i_clk);
            o_tx_bus <= w;
            @(posedge i_clk);
            o_tx_bus <= idle_of(w);
        end
    endtask

    // Writes on every edge and ignores ready, breaking the backpressure limit on purpose.
    task automatic flood(input seg_bus_pkg::bus_t w, input int count);
        for (int i = 0; i < count; i++)
        begin
            @(posedge i_clk);
            o_tx_bus <= w;
            w[0].payload = w[0].payload + 128'h1;
        end
        @(posedge i_clk);
        o_tx_bus <= idle_of(w);
    endtask
endmodule // user_packet_agent

`default_nettype wire

// ### test/segmented_packet_bus_100g_bench.sv
// Self-checking bench: words go out on the lanes and loop back into the receiver.
// Assumes the design, its package, the checker and the user agent are compiled first.
`default_nettype none

module segmented_packet_bus_100g_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // ****************************************************************
    // Rows: per-segment qualifiers, shared empty count, expected empty
    // ****************************************************************
    typedef struct packed {
        logic [3:0] valid;
        logic [3:0] first;
        logic [3:0] last;
        logic [3:0] bad;
        logic [3:0] empty;
        logic [3:0] exp_empty;
    } row_t;
    localparam int ROWS = 6;
    localparam row_t ROW_TABLE [ROWS] = '{
        '{4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0},
        '{4'hF, 4'h1, 4'h8, 4'h0, 4'hF, 4'hF},
        '{4'h3, 4'h1, 4'h2, 4'h2, 4'hF, 4'h8},
        '{4'h7, 4'h3, 4'h5, 4'hF, 4'h5, 4'h0},
        '{4'h1, 4'hE, 4'hE, 4'h1, 4'h9, 4'h0},
        '{4'h3, 4'h0, 4'h2, 4'h0, 4'h1, 4'h1}
    };

    logic clk = 1'b0;
    logic reset;
    logic ten_lane;
    seg_bus_pkg::lanes_t lanes_tx;
    seg_bus_pkg::lanes_t lanes_rx;
    seg_bus_pkg::lanes_t lag1;
    seg_bus_pkg::lanes_t lag2;
    seg_bus_pkg::bus_t tx_bus;
    seg_bus_pkg::bus_t rx_bus;
    logic tx_ready;
    logic tx_overflow;
    logic rx_locked;
    logic watch;
    logic seen_stall;
    logic seen_overflow;
    int bad_count;
    int tests_run;

    segmented_packet_bus_100g #(
        .FIFO_DEPTH(16),
        .READY_SLACK(4)
    ) dut_u (
        .i_clk(clk),
        .i_reset(reset),
        .i_ten_lane_mode(ten_lane),
        .i_tx_bus(tx_bus),
        .o_tx_ready(tx_ready),
        .o_tx_overflow(tx_overflow),
        .o_serdes_tx(lanes_tx),
        .i_serdes_rx(lanes_rx),
        .o_rx_bus(rx_bus),
        .o_rx_locked(rx_locked)
    );
    user_packet_agent agent_u (.i_clk(clk), .i_ready(tx_ready), .o_tx_bus(tx_bus));

    always #2.5 clk = ~clk;

    // Lanes come back swapped and up to two cycles apart, so the receiver must deskew and reorder.
    always @(posedge clk)
    begin
        lag1 <= lanes_tx;
        lag2 <= lag1;
    end
    assign lanes_rx = {lag1[1], lag2[3], lag1[0], lanes_tx[2]};

    always @(negedge clk)
    begin
        seen_stall <= watch && (seen_stall || !tx_ready);
        seen_overflow <= watch && (seen_overflow || tx_overflow);
    end

    function automatic logic [127:0] masked(input logic [127:0] p, input logic [3:0] n);
        return p & ~((128'h1 << (8 * n)) - 128'h1);
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
        begin
            $display("DONE - PASS");
        end
        else
        begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk_flag(input string name, input logic exp, input logic got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic chk_vec(input string name, input logic [127:0] exp, input logic [127:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic restart(input logic m);
        int n;
        n = 0;
        @(posedge clk);
        reset <= 1'b1;
        ten_lane <= m;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk_flag("ready after reset", 1'b1, tx_ready);
        while (rx_locked !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk_flag("lock", 1'b1, rx_locked);
    endtask

    task automatic run_row(input int r);
        seg_bus_pkg::bus_t w;
        row_t t;
        bit ok;
        int n;
        t = ROW_TABLE[r];
        n = 0;
        for (int s = 0; s < 4; s++)
        begin
            w[s] = '{128'h0F1E2D3C4B5A69788796A5B4C3D2E1F0 ^ {16{8'(r * 4 + s)}}, t.valid[s], t.first[s],
                     t.last[s], t.bad[s], t.empty};
        end
        agent_u.send(w, ok);
        while (ok && rx_bus[0].valid !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        if (!ok || n >= 400)
        begin
            bad_count++;
            $display("ERROR row %0d expected a word seen none", r);
            finish_test();
        end
        for (int s = 0; s < 4; s++)
        begin
            chk_flag("rx valid", t.valid[s], rx_bus[s].valid);
            if (t.valid[s])
            begin
                chk_flag("rx first", t.first[s], rx_bus[s].first);
                chk_flag("rx last", t.last[s], rx_bus[s].last);
                if (t.last[s])
                begin
                    chk_flag("rx bad", t.bad[s], rx_bus[s].bad);
                    chk_vec("rx empty", 128'(t.exp_empty), 128'(rx_bus[s].empty_count));
                end
                if (!(t.last[s] && t.bad[s]))
                    chk_vec("rx payload", masked(w[s].payload, t.last[s] ? t.exp_empty : 4'h0),
                            masked(rx_bus[s].payload, t.last[s] ? t.exp_empty : 4'h0));
            end
        end
    endtask

    initial
    begin
        seg_bus_pkg::bus_t fw;
        int n;
        reset = 1'b1;
        ten_lane = 1'b0;
        watch = 1'b0;
        bad_count = 0;
        tests_run = 0;
        for (int m = 0; m < 2; m++)
        begin
            restart(m[0]);
            for (int r = 0; r < ROWS; r++)
            begin
                run_row(r);
            end
            $display("test rows in mode %0d done", m);
        end
        // Narrow mode drains slowest, so writing past ready there is sure to overflow the buffer.
        fw = '0;
        fw[0] = '{128'h0123456789ABCDEF0123456789ABCDEF, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0};
        @(posedge clk);
        watch = 1'b1;
        agent_u.flood(fw, 24);
        chk_flag("ready fell", 1'b1, seen_stall);
        chk_flag("overflow seen", 1'b1, seen_overflow);
        n = 0;
        while (tx_ready !== 1'b1 && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        chk_flag("ready back", 1'b1, tx_ready);
        $display("test overflow done");
        finish_test();
    end
endmodule // segmented_packet_bus_100g_bench

`default_nettype wire
